// *** hw/omcs_ctrl.v ***
`timescale 1ns/1ps
`include "omcs_defs.vh"

module omcs_ctrl #(
    parameter COOLED = 0,
    parameter TICK_CYCLES = `OMCS_TICK_CYCLES,
    parameter START_US = `OMCS_T_START_US,
    parameter START_COOLED_US = `OMCS_T_START_COOLED_US,
    parameter MGMT_US = `OMCS_T_START_US,
    parameter POWER_US = `OMCS_T_POWER_US,
    parameter ON_US = `OMCS_T_ON_US,
    parameter FAULT_US = `OMCS_T_FAULT_US,
    parameter FAULT_COOLED_US = `OMCS_T_FAULT_COOLED_US,
    parameter RESET_US = `OMCS_T_RESET_US,
    parameter RATE_US = `OMCS_T_RATE_US,
    parameter RATE_FC_US = `OMCS_T_RATE_FC_US
) (
    input wire clock,
    input wire rst,
    input wire laser_off_req,
    input wire laser_fault_in,
    input wire signal_lost_in,
    input wire rate_select_low,
    input wire rate_select_high,
    input wire fc_mode,
    input wire high_power_req,
    output reg laser_on,
    output reg tx_fault,
    output reg rx_los,
    output reg mgmt_ready,
    output reg operational,
    output reg high_power,
    output reg rate_stable,
    output reg [1:0] rate_sel
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;
    wire dis_s = sync2_reg[0];
    wire flt_s = sync2_reg[1];
    wire los_s = sync2_reg[2];
    wire [1:0] rs_s = sync2_reg[4:3];
    wire fc_s = sync2_reg[5];
    wire hp_s = sync2_reg[6];

    always @(posedge clock) begin
        if (rst) begin
            sync1_reg <= 7'h01;
            sync2_reg <= 7'h01;
        end else begin
            sync1_reg <= {high_power_req, fc_mode, rate_select_high, rate_select_low,
                          signal_lost_in, laser_fault_in, laser_off_req};
            sync2_reg <= sync1_reg;
        end
    end

    wire tick_us;

    omcs_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tb (
        .clock(clock),
        .rst(rst),
        .tick_us(tick_us)
    );

    function [`OMCS_US_W-1:0] inc_us;
        input [`OMCS_US_W-1:0] v;
        input t;
        begin
            inc_us = (t && v != {`OMCS_US_W{1'b1}}) ? v + 27'h1 : v;
        end
    endfunction

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    reg [2:0] state_reg;
    reg [`OMCS_US_W-1:0] seq_us_reg;
    reg [`OMCS_US_W-1:0] boot_us_reg;
    reg [`OMCS_US_W-1:0] hold_us_reg;
    reg [`OMCS_US_W-1:0] rate_us_reg;
    reg dis_d_reg;
    reg [1:0] rs_d_reg;

    // ----------------------------------------
    // State codes and window limits
    // ----------------------------------------
    localparam [2:0] ST_START = `OMCS_ST_START;
    localparam [2:0] ST_RUN = `OMCS_ST_RUN;
    localparam [2:0] ST_OFF = `OMCS_ST_OFF;
    localparam [2:0] ST_FAULT = `OMCS_ST_FAULT;
    localparam [2:0] ST_POWER = `OMCS_ST_POWER;
    // Each limit except RESET_LIM is one tick short because the compare sees the count a cycle late.
    localparam [`OMCS_US_W-1:0] START_LIM = (COOLED ? START_COOLED_US : START_US) - 1;
    localparam [`OMCS_US_W-1:0] MGMT_LIM = MGMT_US - 1;
    localparam [`OMCS_US_W-1:0] POWER_LIM = POWER_US - 1;
    localparam [`OMCS_US_W-1:0] RESET_LIM = RESET_US;
    localparam [`OMCS_US_W-1:0] RATE_LIM = RATE_US - 1;
    localparam [`OMCS_US_W-1:0] RATE_FC_LIM = RATE_FC_US - 1;
    wire [`OMCS_US_W-1:0] rate_lim = fc_s ? RATE_FC_LIM : RATE_LIM;

    always @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_START;
            seq_us_reg <= {`OMCS_US_W{1'b0}};
            boot_us_reg <= {`OMCS_US_W{1'b0}};
            hold_us_reg <= {`OMCS_US_W{1'b0}};
            rate_us_reg <= {`OMCS_US_W{1'b0}};
            dis_d_reg <= 1'b1;
            rs_d_reg <= 2'h0;
            laser_on <= 1'b0;
            tx_fault <= 1'b0;
            rx_los <= 1'b1;
            mgmt_ready <= 1'b0;
            operational <= 1'b0;
            high_power <= 1'b0;
            rate_stable <= 1'b0;
            rate_sel <= 2'h0;
        end else begin
            dis_d_reg <= dis_s;
            rs_d_reg <= rs_s;
            rx_los <= los_s;
            boot_us_reg <= inc_us(boot_us_reg, tick_us);
            if (boot_us_reg >= MGMT_LIM) begin
                mgmt_ready <= 1'b1;
            end
            seq_us_reg <= inc_us(seq_us_reg, tick_us);
            if (rs_s != rs_d_reg) begin
                rate_us_reg <= {`OMCS_US_W{1'b0}};
                rate_stable <= 1'b0;
            end else begin
                rate_us_reg <= inc_us(rate_us_reg, tick_us);
                if (rate_us_reg >= rate_lim) begin
                    rate_sel <= rs_s;
                    rate_stable <= 1'b1;
                end
            end
            if (dis_s) begin
                hold_us_reg <= inc_us(hold_us_reg, tick_us);
            end else begin
                hold_us_reg <= {`OMCS_US_W{1'b0}};
            end
            if (flt_s && state_reg != ST_FAULT) begin
                state_reg <= ST_FAULT;
                tx_fault <= 1'b1;
                laser_on <= 1'b0;
                operational <= 1'b0;
            end else begin
                case (state_reg)
                    ST_START: begin
                        if (dis_s) begin
                            laser_on <= 1'b0;
                            seq_us_reg <= {`OMCS_US_W{1'b0}};
                        end else if (seq_us_reg >= START_LIM) begin
                            state_reg <= ST_RUN;
                            laser_on <= 1'b1;
                            operational <= 1'b1;
                        end
                    end
                    ST_RUN: begin
                        if (dis_s && !dis_d_reg) begin
                            state_reg <= ST_OFF;
                            laser_on <= 1'b0;
                        end else if (hp_s != high_power) begin
                            // Compared with the applied level, so a request made while off is kept.
                            state_reg <= ST_POWER;
                            seq_us_reg <= {`OMCS_US_W{1'b0}};
                        end
                    end
                    ST_OFF: begin
                        if (!dis_s) begin
                            state_reg <= ST_RUN;
                            laser_on <= 1'b1;
                        end
                    end
                    ST_POWER: begin
                        // The laser keeps obeying the disable pin during a level change.
                        laser_on <= !dis_s;
                        if (seq_us_reg >= POWER_LIM) begin
                            state_reg <= dis_s ? ST_OFF : ST_RUN;
                            high_power <= hp_s;
                        end
                    end
                    ST_FAULT: begin
                        if (hold_us_reg >= RESET_LIM && !dis_s) begin
                            state_reg <= ST_START;
                            tx_fault <= 1'b0;
                            seq_us_reg <= {`OMCS_US_W{1'b0}};
                        end
                    end
                    default: begin
                        state_reg <= ST_START;
                    end
                endcase
            end
        end
    end
endmodule // omcs_ctrl

// *** hw/omcs_defs.vh ***
// Functional notes
// - Laser off within 100 us of disable
// - Laser on within 2 ms of enable
// - Management interface ready within 300 ms
// - Non-cooled start-up complete within 300 ms
// - Cooled start-up complete within 90 s
// - High power entry complete within 300 ms
// - High power exit complete within 300 ms
// - Fault flag within 1 ms or 50 ms
// - Disable held 10 us clears latched fault
// - Rate select settles in 500 us or 10 ms
// - Loss flag asserts within 100 us
// - Loss flag negates within 100 us
`ifndef OMCS_DEFS_VH
`define OMCS_DEFS_VH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define OMCS_CLK_MHZ 250
`define OMCS_T_OFF_US 100
`define OMCS_T_ON_US 2000
`define OMCS_T_START_US 300000
`define OMCS_T_START_COOLED_US 90000000
`define OMCS_T_POWER_US 300000
`define OMCS_T_FAULT_US 1000
`define OMCS_T_FAULT_COOLED_US 50000
`define OMCS_T_RESET_US 10
`define OMCS_T_RATE_FC_US 500
`define OMCS_T_RATE_US 10000
`define OMCS_T_LOS_US 100

// Timebase tick every microsecond.
`define OMCS_TICK_CYCLES (`OMCS_CLK_MHZ)
`define OMCS_TB_W 8
`define OMCS_US_W 27

// Sequencer states.
`define OMCS_ST_START 3'h0
`define OMCS_ST_RUN 3'h1
`define OMCS_ST_OFF 3'h2
`define OMCS_ST_FAULT 3'h3
`define OMCS_ST_POWER 3'h4

`endif

// *** hw/omcs_timebase.v ***
`timescale 1ns/1ps
`include "omcs_defs.vh"

// ----------------------------------------
// One microsecond tick shared by every window
// ----------------------------------------
module omcs_timebase #(
    parameter TICK_CYCLES = `OMCS_TICK_CYCLES
) (
    input wire clock,
    input wire rst,
    output reg tick_us
);
    localparam [`OMCS_TB_W-1:0] TICK_LAST = TICK_CYCLES - 1;
    reg [`OMCS_TB_W-1:0] cnt_reg;

    always @(posedge clock) begin
        if (rst) begin
            cnt_reg <= {`OMCS_TB_W{1'b0}};
            tick_us <= 1'b0;
        end else if (cnt_reg == TICK_LAST) begin
            cnt_reg <= {`OMCS_TB_W{1'b0}};
            tick_us <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            tick_us <= 1'b0;
        end
    end
endmodule // omcs_timebase

// *** sim/omcs_host.sv ***
`timescale 1ns/1ps
// --------
// Host controller pin drivers
// --------
module omcs_host (
    input wire clock,
    input wire [6:0] cmd,
    output reg laser_off_req = 1'b1,
    output reg laser_fault_in = 1'b0,
    output reg signal_lost_in = 1'b0,
    output reg rate_select_low = 1'b0,
    output reg rate_select_high = 1'b0,
    output reg fc_mode = 1'b0,
    output reg high_power_req = 1'b0
);
    // Commands reach the pins at falling edges; a fault reset is a held disable.
    always @(negedge clock) begin
        {high_power_req, fc_mode, rate_select_high, rate_select_low, signal_lost_in,
            laser_fault_in, laser_off_req} <= cmd;
    end
endmodule // omcs_host

// *** sim/omcs_props.sv ***
`timescale 1ns/1ps
// --------
// Response windows seen at the control block's ports
// --------
module omcs_props #(
    parameter TICK_CYCLES = 250,
    parameter START_US = 300000,
    parameter MGMT_US = 300000,
    parameter POWER_US = 300000,
    parameter RATE_US = 10000,
    parameter RATE_FC_US = 500
) (
    input wire clock,
    input wire rst,
    input wire laser_off_req,
    input wire laser_fault_in,
    input wire signal_lost_in,
    input wire rate_select_low,
    input wire rate_select_high,
    input wire fc_mode,
    input wire high_power_req,
    input wire laser_on,
    input wire tx_fault,
    input wire rx_los,
    input wire mgmt_ready,
    input wire operational,
    input wire high_power,
    input wire rate_stable,
    input wire [1:0] rate_sel
);
    integer up_c, st_c, pw_c, rt_c;
    // Cycles spent in each pending window; up_c holds once its goal is met, the others clear.
    always @(posedge clock) begin
        if (rst) begin
            up_c <= 0;
            st_c <= 0;
            pw_c <= 0;
            rt_c <= 0;
        end else begin
            up_c <= mgmt_ready ? up_c : up_c + 1;
            st_c <= (operational | laser_off_req | tx_fault | laser_fault_in) ? 0 : st_c + 1;
            pw_c <= ((high_power == high_power_req) | !operational | tx_fault) ? 0 : pw_c + 1;
            rt_c <= (rate_sel == {rate_select_high, rate_select_low}) ? 0 : rt_c + 1;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    a_off_fast: assert property ($rose(laser_off_req) |-> ##[1:6] !laser_on)
        else $error("laser stayed on");
    a_on_fast: assert property ($fell(laser_off_req) && operational && !tx_fault
        |-> ##[1:6] laser_on) else $error("laser stayed off");
    a_mgmt_time: assert property (up_c <= MGMT_US * TICK_CYCLES + 8)
        else $error("management late");
    a_mgmt_stays: assert property (mgmt_ready |=> mgmt_ready) else $error("ready dropped");
    a_start_time: assert property (st_c <= START_US * TICK_CYCLES + 8)
        else $error("start-up late");
    a_power_time: assert property (pw_c <= POWER_US * TICK_CYCLES + 8)
        else $error("power level late");
    a_fault_flag: assert property ($rose(laser_fault_in) |-> ##[1:5] tx_fault)
        else $error("fault flag late");
    a_fault_hold: assert property (!laser_off_req [*6] ##0 tx_fault |=> tx_fault)
        else $error("fault flag lost");
    a_rate_time: assert property (rt_c <= (fc_mode ? RATE_FC_US : RATE_US) * TICK_CYCLES + 12)
        else $error("rate late");
    a_los_set: assert property (signal_lost_in [*5] |-> rx_los) else $error("los missing");
    a_los_clear: assert property (!signal_lost_in [*5] |-> !rx_los) else $error("los stuck");
    a_off_level: assert property (laser_off_req [*6] |-> !laser_on) else $error("laser on");
    cover property ($fell(tx_fault));
    cover property ($rose(high_power));
    cover property ($rose(laser_on));
    cover property ($rose(rate_stable));
endmodule // omcs_props

bind omcs_ctrl omcs_props #(.TICK_CYCLES(TICK_CYCLES),
    .START_US(COOLED ? START_COOLED_US : START_US), .MGMT_US(MGMT_US),
    .POWER_US(POWER_US), .RATE_US(RATE_US), .RATE_FC_US(RATE_FC_US)) omcs_props_inst (.*);

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// --------
// Bench
// --------
module testbench;
    localparam TK = 2;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [6:0] cmd = 7'h01;
    reg [31:0] r;
    wire laser_off_req, laser_fault_in, signal_lost_in, rate_select_low, rate_select_high;
    wire fc_mode, high_power_req, laser_on, tx_fault, rx_los, mgmt_ready, operational;
    wire high_power, rate_stable;
    wire [1:0] rate_sel;
    wire operational_c;
    integer n_fail = 0;
    integer num_checks = 0;
    integer i;
    initial forever #2 clock = ~clock;
    omcs_host omcs_host_inst (.*);
    omcs_ctrl #(.TICK_CYCLES(TK), .START_US(20), .MGMT_US(20), .POWER_US(20), .RATE_US(10),
        .RATE_FC_US(5)) omcs_ctrl_inst (.*);
    omcs_ctrl #(.COOLED(1), .TICK_CYCLES(TK), .START_COOLED_US(30), .MGMT_US(20), .POWER_US(20),
        .RATE_US(10), .RATE_FC_US(5)) omcs_ctrl_cooled_inst (.clock(clock), .rst(rst),
        .laser_off_req(laser_off_req), .laser_fault_in(laser_fault_in),
        .signal_lost_in(signal_lost_in), .rate_select_low(rate_select_low),
        .rate_select_high(rate_select_high), .fc_mode(fc_mode), .high_power_req(high_power_req),
        .laser_on(), .tx_fault(), .rx_los(), .mgmt_ready(), .operational(operational_c),
        .high_power(), .rate_stable(), .rate_sel());
    task cy(input integer n);
        repeat (n) @(negedge clock);
    endtask
    task chk(input string nm, input [1:0] e, input [1:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        r = $urandom(32'hfedf);
        cy(2);
        rst = 1'b0;
        chk("reset", 2'b01, {tx_fault, rx_los});
        cmd[0] = 1'b0;
        cy(20 * TK + 12);
        chk("operational", 1, operational);
        chk("mgmt_ready", 1, mgmt_ready);
        chk("operational_c", 0, operational_c);
        for (i = 0; i < 6; i = i + 1) begin
            r = $urandom;
            cmd[5:3] = r[2:0];
            cmd[2] = r[3];
            cy(10 * TK + 14);
            chk("rate_sel", r[1:0], rate_sel);
            chk("rate_stable", 1, rate_stable);
            chk("rx_los", r[3], rx_los);
        end
        chk("operational_c", 1, operational_c);
        cmd[0] = 1'b1;
        cy(8);
        chk("laser_on", 0, laser_on);
        cmd[0] = 1'b0;
        cy(8);
        chk("laser_on", 1, laser_on);
        for (i = 0; i < 2; i = i + 1) begin
            cmd[6] = ~cmd[6];
            cy(20 * TK + 14);
            chk("high_power", cmd[6], high_power);
        end
        cmd[1] = 1'b1;
        cy(8);
        chk("tx_fault", 1, tx_fault);
        cmd[1] = 1'b0;
        cmd[0] = 1'b1;
        cy(4 * TK);
        cmd[0] = 1'b0;
        cy(10);
        chk("tx_fault", 1, tx_fault);
        cmd[0] = 1'b1;
        cy(10 * TK + 6);
        cmd[0] = 1'b0;
        cy(10);
        chk("tx_fault", 0, tx_fault);
        cy(20 * TK + 12);
        chk("operational", 1, operational);
        report_and_stop;
    end
    initial begin
        #20000;
        n_fail = n_fail + 1;
        report_and_stop;
    end
endmodule // testbench
